// ==== sim/pams_auto_switch_monitor.sv ====
// Purpose: port checks of the auto switch block
// Assumes: one clock domain
// Notes:   bound to the block
`timescale 1ns/1ps
`default_nettype none
`include "pams_map.svh"
module pams_auto_switch_monitor
  import pams_pkg::*;
(
  input wire logic                    sys_clk,
  input wire logic                    reset_n,
  input wire logic                    clk_en,
  input wire logic [`PAMS_ADDR_W-1:0] reg_addr,
  input wire logic                    reg_rd,
  input wire logic [31:0]             reg_rdata,
  input wire logic                    loop_sample_valid,
  input wire logic                    limit_fault,
  input wire pams_cfg_t               active_cfg,
  input wire pams_ctl_t               active_ctl,
  input wire pams_band_t              active_band,
  input wire logic                    ab_fault_kill,
  input wire logic                    c_fault_kill
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic thr_rd;
  // read of a threshold slot
  assign thr_rd = clk_en && reg_rd && reg_addr >= `PAMS_OFF_HI_UPPER
                  && reg_addr <= `PAMS_OFF_LO_LOWER;
  AST_THR_BITS: assert property (thr_rd |=> reg_rdata[31:18] == 14'h0 &&
    reg_rdata[3:0] == 4'h0) else $error("threshold read has stray bits");
  AST_BAND_CAUSE: assert property ($changed(active_band) |->
    $past(loop_sample_valid, 2)) else $error("band moved without sample");
  AST_ACCEL_SRC: assert property (active_ctl.use_loop_accel ==
    active_cfg.loop_accel_input_enable) else $error("waveform source wrong");
  AST_LIMIT_MODE: assert property (active_ctl.limit_enable |->
    active_cfg.mode == PAMS_MODE_NORMAL) else $error("limit outside normal mode");
  AST_FIXED_DUTY: assert property (active_ctl.use_fixed_duty |->
    active_cfg.mode == PAMS_MODE_RESONANT) else $error("fixed duty outside resonant");
  AST_AB_KILL: assert property (clk_en && limit_fault && active_cfg.ab_output_limit_affect
    ##1 active_cfg.ab_output_limit_affect |-> ab_fault_kill) else $error("ab kill missing");
  AST_KILL_QUIET: assert property (clk_en && !limit_fault |=>
    !ab_fault_kill && !c_fault_kill) else $error("kill without fault");
  AST_SEL_CLIP: assert property (active_cfg.b_output_selector <= 4'h8 &&
    active_cfg.a_output_selector <= 4'h8) else $error("selector out of range");
  cover property (active_band == PAMS_USE_MAX);
  cover property (ab_fault_kill);
  cover property (active_ctl.use_fixed_duty);
endmodule : pams_auto_switch_monitor
bind pams_auto_switch pams_auto_switch_monitor u_mon (.sys_clk, .reset_n, .clk_en, .reg_addr,
  .reg_rd, .reg_rdata, .loop_sample_valid, .limit_fault, .active_cfg, .active_ctl,
  .active_band, .ab_fault_kill, .c_fault_kill);
`default_nettype wire

// ==== sim/pams_auto_switch_tb.sv ====
// Purpose: self-checking bench of the auto switch block
// Assumes: thresholds 3000/2000/1000/0800
// Notes:   xorshift stimulus, fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "pams_map.svh"
module pams_auto_switch_tb
  import pams_pkg::*;
;
  logic        sys_clk, reset_n, clk_en, reg_wr, reg_rd, go, limit_fault;
  logic        loop_sample_valid, ab_fault_kill, c_fault_kill;
  logic [23:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, w, wmax, wmid;
  logic [17:0] loop_sample, filter_duty, level, resonant_duty;
  logic [1:0]  lag;
  pams_cfg_t   active_cfg;
  pams_ctl_t   active_ctl;
  pams_band_t  active_band, band;
  int          miscompares, compares;
  pams_auto_switch u_dut (.sys_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .loop_sample_valid, .loop_sample, .filter_duty, .limit_fault, .active_cfg,
    .active_ctl, .active_band, .resonant_duty, .ab_fault_kill, .c_fault_kill);
  pams_loop_model u_loop (.sys_clk, .reset_n, .go, .lag, .level, .loop_sample_valid,
    .loop_sample, .filter_duty);
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] cfg_of(logic [31:0] v);
    return {v[31:28] > 4'h8 ? 4'h0 : v[31:28], v[27:24] > 4'h8 ? 4'h0 : v[27:24],
            v[23], v[20], v[19], v[12], v[6:4], v[1]};
  endfunction : cfg_of
  function automatic logic [5:0] ctl_of(logic [31:0] v);
    return {v[6:4] == 3'h0 && v[19], (v[6:4] == 3'h1 || v[6:4] == 3'h2) && v[19],
            v[20], v[23], v[6:4] == 3'h1 && v[12], v[1]};
  endfunction : ctl_of
  function automatic pams_band_t nxt(pams_band_t b, logic [17:0] s);
    if (s >= 18'h3000) return PAMS_USE_MAX;
    if (s < 18'h0800) return PAMS_USE_MID;
    if (b == PAMS_USE_MAX && s < 18'h2000 && s >= 18'h1000) return PAMS_USE_MID;
    return b;
  endfunction : nxt
  task automatic check(string what, logic [31:0] exp, logic [31:0] act);
    compares++;
    if (act !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, act);
    end
  endtask : check
  task automatic wr(logic [23:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(logic [23:0] a, logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", exp, reg_rdata);
    @(posedge sys_clk);
  endtask : rd
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // watchdog on the whole run
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
  // main sequence
  initial begin
    seed = 32'h67110e64;
    {miscompares, compares} = '0;
    {reset_n, reg_wr, reg_rd, go, limit_fault, lag, level, reg_addr, reg_wdata} = '0;
    clk_en = 1'b1;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) rd(`PAMS_OFF_HI_UPPER + 24'(4 * i), i == 5 ? 32'h2 : 32'h0);
    rd(24'h1d0080, 32'h0);
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      wr(`PAMS_OFF_HI_UPPER + 24'(4 * i), w);
      rd(`PAMS_OFF_HI_UPPER + 24'(4 * i), w & 32'h0003_fff0);
      wr(`PAMS_OFF_HI_UPPER + 24'(4 * i), i == 0 ? 32'h3000 : 32'h4000 >> i);
    end
    for (int m = 0; m < 5; m++) begin
      w = rnd() | 32'h0008_0000;
      w[31:24] = {4'(2 * m), 4'(2 * m + 1)};
      w[6:4] = 3'(m);
      wr(`PAMS_OFF_CFG_MID, w);
      rd(`PAMS_OFF_CFG_MID, w & 32'hff98_1072);
      check("cfg", 32'(cfg_of(w)), 32'(active_cfg));
      check("ctl", 32'(ctl_of(w)), 32'(active_ctl));
    end
    clk_en <= 1'b0;
    wr(`PAMS_OFF_CFG_MID, 32'h0);
    clk_en <= 1'b1;
    rd(`PAMS_OFF_CFG_MID, w & 32'hff98_1072);
    wmax = rnd() | 32'h0010_1000;
    wmax[6:4] = 3'h1;
    wmid = rnd() | 32'h0080_0000;
    wmid[6:4] = 3'h2;
    wr(`PAMS_OFF_CFG_MAX, wmax);
    wr(`PAMS_OFF_CFG_MID, wmid);
    band = PAMS_USE_MID;
    for (int i = 0; i < 30; i++) begin
      w = rnd();
      level <= i < 7 ? 18'h2800 - 18'(i < 6 ? 18'h0 : 18'h2001) : {4'h0, w[13:0]};
      if (i < 6) level <= i[0] ? 18'h3000 + 18'(i * 64) : 18'h2000 - 18'(i * 512);
      lag <= w[17:16];
      limit_fault <= w[31];
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (8) @(posedge sys_clk);
      band = nxt(band, level);
      w = band == PAMS_USE_MAX ? wmax : wmid;
      check("band", 32'(band), 32'(active_band));
      check("cfg", 32'(cfg_of(w)), 32'(active_cfg));
      check("ab_kill", 32'(limit_fault & w[20]), 32'(ab_fault_kill));
      check("c_kill", 32'(limit_fault & w[23]), 32'(c_fault_kill));
      if (band == PAMS_USE_MAX) check("duty", 32'h3000, 32'(resonant_duty));
    end
    conclude();
  end
endmodule : pams_auto_switch_tb
`default_nettype wire

// ==== sim/pams_loop_model.sv ====
// Purpose: control loop model feeding samples and duty
// Assumes: shares the block clock
// Notes:   sample arrives 1..4 cycles after go
`timescale 1ns/1ps
`default_nettype none
module pams_loop_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        go,
  input  wire logic [1:0]  lag,
  input  wire logic [17:0] level,
  output logic             loop_sample_valid,
  output logic      [17:0] loop_sample,
  output logic      [17:0] filter_duty
);
  logic [2:0] cnt_r;
  // deliver after lag, scramble the bus otherwise
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 3'h0;
      loop_sample_valid <= 1'b0;
      loop_sample <= 18'h0;
      filter_duty <= 18'h0;
    end else begin
      cnt_r <= go ? {1'b0, lag} + 3'h1 : cnt_r - {2'h0, cnt_r != 3'h0};
      loop_sample_valid <= cnt_r == 3'h1;
      loop_sample <= cnt_r == 3'h1 ? level : ~loop_sample;
      filter_duty <= filter_duty + 18'h1357;
    end
  end
endmodule : pams_loop_model
`default_nettype wire

// ==== src/pams_auto_switch.sv ====
// Purpose: auto mode switching registers and configuration selection for one pulse generator
// Assumes: single clock, register port with read data one cycle after the read strobe
// Notes:   high upper threshold register is included so both bands are complete
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pams_map.svh"

module pams_auto_switch
  import pams_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  input  wire logic                     clk_en,
  input  wire logic [`PAMS_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  input  wire logic                     loop_sample_valid,
  input  wire logic [17:0]              loop_sample,
  input  wire logic [17:0]              filter_duty,
  input  wire logic                     limit_fault,
  output pams_cfg_t                     active_cfg,
  output pams_ctl_t                     active_ctl,
  output pams_band_t                    active_band,
  output logic      [17:0]              resonant_duty,
  output logic                          ab_fault_kill,
  output logic                          c_fault_kill
);

  // threshold and configuration storage
  logic [13:0] hi_upper_r;
  logic [13:0] hi_lower_r;
  logic [13:0] lo_upper_r;
  logic [13:0] lo_lower_r;
  logic [31:0] cfg_max_r;
  logic [31:0] cfg_mid_r;
  pams_band_t  band_r;
  pams_band_t  band_nxt;
  pams_cfg_t   cfg_sel;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_mux;

  // coarse threshold widened to full 18-bit compare scale
  function automatic logic [17:0] thr_full(input logic [13:0] coarse);
    thr_full = {coarse, 4'h0};
  endfunction : thr_full

  // keep only writable bits of a configuration word
  function automatic logic [31:0] cfg_mask(input logic [31:0] w);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[`PAMS_B_SEL_MSB:`PAMS_B_SEL_LSB] = w[`PAMS_B_SEL_MSB:`PAMS_B_SEL_LSB];
    m[`PAMS_A_SEL_MSB:`PAMS_A_SEL_LSB] = w[`PAMS_A_SEL_MSB:`PAMS_A_SEL_LSB];
    m[`PAMS_C_LIM_BIT]   = w[`PAMS_C_LIM_BIT];
    m[`PAMS_AB_LIM_BIT]  = w[`PAMS_AB_LIM_BIT];
    m[`PAMS_MATCH_BIT]   = w[`PAMS_MATCH_BIT];
    m[`PAMS_FIXDUTY_BIT] = w[`PAMS_FIXDUTY_BIT];
    m[`PAMS_MODE_MSB:`PAMS_MODE_LSB] = w[`PAMS_MODE_MSB:`PAMS_MODE_LSB];
    m[`PAMS_ACCEL_BIT]   = w[`PAMS_ACCEL_BIT];
    cfg_mask = m;
  endfunction : cfg_mask

  // unpack a stored word into the configuration struct
  function automatic pams_cfg_t cfg_unpack(input logic [31:0] w);
    pams_cfg_t c;
    c.b_output_selector           = w[`PAMS_B_SEL_MSB:`PAMS_B_SEL_LSB];
    c.a_output_selector           = w[`PAMS_A_SEL_MSB:`PAMS_A_SEL_LSB];
    c.c_output_limit_affect       = w[`PAMS_C_LIM_BIT];
    c.ab_output_limit_affect      = w[`PAMS_AB_LIM_BIT];
    c.limit_or_pulse_match_enable = w[`PAMS_MATCH_BIT];
    c.resonant_fixed_duty_select  = w[`PAMS_FIXDUTY_BIT];
    c.mode                        = w[`PAMS_MODE_MSB:`PAMS_MODE_LSB];
    c.loop_accel_input_enable     = w[`PAMS_ACCEL_BIT];
    cfg_unpack = c;
  endfunction : cfg_unpack

  // selector codes above the last defined entry fall back to pass-through
  function automatic logic [3:0] sel_clip(input logic [3:0] s);
    sel_clip = (s > `PAMS_SEL_MAX_CODE) ? PAMS_SEL_PASS : s;
  endfunction : sel_clip

  // bus strobes only count while the block is enabled
  assign wr_hit = clk_en & reg_wr;
  assign rd_hit = clk_en & reg_rd;

  // write decode, one strobe per register slot
  logic        wr_hi_upper;
  logic        wr_hi_lower;
  logic        wr_lo_upper;
  logic        wr_lo_lower;
  logic        wr_cfg_max;
  logic        wr_cfg_mid;
  assign wr_hi_upper = wr_hit & (reg_addr == `PAMS_OFF_HI_UPPER);
  assign wr_hi_lower = wr_hit & (reg_addr == `PAMS_OFF_HI_LOWER);
  assign wr_lo_upper = wr_hit & (reg_addr == `PAMS_OFF_LO_UPPER);
  assign wr_lo_lower = wr_hit & (reg_addr == `PAMS_OFF_LO_LOWER);
  assign wr_cfg_max  = wr_hit & (reg_addr == `PAMS_OFF_CFG_MAX);
  assign wr_cfg_mid  = wr_hit & (reg_addr == `PAMS_OFF_CFG_MID);

  // high upper threshold, low nibble dropped
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_upper_r <= `PAMS_THR_RST;
    end else if (wr_hi_upper) begin
      hi_upper_r <= reg_wdata[`PAMS_THR_MSB:`PAMS_THR_LSB];
    end
  end

  // high lower threshold, low nibble dropped
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_lower_r <= `PAMS_THR_RST;
    end else if (wr_hi_lower) begin
      hi_lower_r <= reg_wdata[`PAMS_THR_MSB:`PAMS_THR_LSB];
    end
  end

  // low upper threshold, low nibble dropped
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lo_upper_r <= `PAMS_THR_RST;
    end else if (wr_lo_upper) begin
      lo_upper_r <= reg_wdata[`PAMS_THR_MSB:`PAMS_THR_LSB];
    end
  end

  // low lower threshold, low nibble dropped
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lo_lower_r <= `PAMS_THR_RST;
    end else if (wr_lo_lower) begin
      lo_lower_r <= reg_wdata[`PAMS_THR_MSB:`PAMS_THR_LSB];
    end
  end

  // max word, reserved bits kept zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_max_r <= `PAMS_CFG_MAX_RST;
    end else if (wr_cfg_max) begin
      cfg_max_r <= cfg_mask(reg_wdata);
    end
  end

  // mid word, reserved bits kept zero; accel enable set out of reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_mid_r <= `PAMS_CFG_MID_RST;
    end else if (wr_cfg_mid) begin
      cfg_mid_r <= cfg_mask(reg_wdata);
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      `PAMS_OFF_HI_UPPER: rd_mux = {14'h0000, thr_full(hi_upper_r)};
      `PAMS_OFF_HI_LOWER: rd_mux = {14'h0000, thr_full(hi_lower_r)};
      `PAMS_OFF_LO_UPPER: rd_mux = {14'h0000, thr_full(lo_upper_r)};
      `PAMS_OFF_LO_LOWER: rd_mux = {14'h0000, thr_full(lo_lower_r)};
      `PAMS_OFF_CFG_MAX:  rd_mux = cfg_max_r;
      `PAMS_OFF_CFG_MID:  rd_mux = cfg_mid_r;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      reg_rdata <= rd_mux;
    end
  end

  // threshold comparisons against the full-scale sample
  logic        at_hi_upper;
  logic        below_hi_lower;
  logic        at_lo_upper;
  logic        below_lo_lower;
  assign at_hi_upper    = (loop_sample >= thr_full(hi_upper_r));
  assign below_hi_lower = (loop_sample < thr_full(hi_lower_r));
  assign at_lo_upper    = (loop_sample >= thr_full(lo_upper_r));
  assign below_lo_lower = (loop_sample < thr_full(lo_lower_r));

  // band decision: at or above high upper -> max, below low lower -> mid, max below high lower and at or above low upper -> mid, else hold
  // a sample between the pair of one band never moves the choice
  always_comb begin
    band_nxt = band_r;
    if (at_hi_upper) begin
      band_nxt = PAMS_USE_MAX;
    end else if (below_lo_lower) begin
      band_nxt = PAMS_USE_MID;
    end else if (band_r == PAMS_USE_MAX && below_hi_lower && at_lo_upper) begin
      band_nxt = PAMS_USE_MID; // left high band downward
    end else begin
      band_nxt = band_r; // inside a hysteresis band: hold
    end
  end

  // band state only moves on a valid sample
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      band_r <= PAMS_USE_MID;
    end else if (clk_en && loop_sample_valid) begin
      band_r <= band_nxt;
    end
  end

  // pick the word for the current band
  always_comb begin
    cfg_sel = cfg_unpack((band_r == PAMS_USE_MAX) ? cfg_max_r : cfg_mid_r);
    cfg_sel.b_output_selector = sel_clip(cfg_sel.b_output_selector);
    cfg_sel.a_output_selector = sel_clip(cfg_sel.a_output_selector);
  end

  // mode decode of the selected word
  logic        mode_normal;
  logic        mode_resonant;
  logic        mode_multi;
  assign mode_normal   = (cfg_sel.mode == PAMS_MODE_NORMAL);
  assign mode_resonant = (cfg_sel.mode == PAMS_MODE_RESONANT);
  assign mode_multi    = (cfg_sel.mode == PAMS_MODE_MULTI);

  // applied configuration and band toward the generator
  // both move on the same edge so they never disagree downstream
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_cfg  <= '0;
      active_band <= PAMS_USE_MID;
    end else if (clk_en) begin
      active_cfg  <= cfg_sel;
      active_band <= band_r;
    end
  end

  // decoded controls; bit 19 means limit or matching by mode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_ctl <= '0;
    end else if (clk_en) begin
      active_ctl.use_loop_accel <= cfg_sel.loop_accel_input_enable;
      active_ctl.limit_enable   <= mode_normal & cfg_sel.limit_or_pulse_match_enable;
      active_ctl.pulse_match    <= (mode_multi | mode_resonant)
                                   & cfg_sel.limit_or_pulse_match_enable;
      active_ctl.ab_limit_gate  <= cfg_sel.ab_output_limit_affect;
      active_ctl.c_limit_gate   <= cfg_sel.c_output_limit_affect;
      active_ctl.use_fixed_duty <= mode_resonant & cfg_sel.resonant_fixed_duty_select;
    end
  end

  // resonant duty from filter, or fixed at the high upper threshold
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      resonant_duty <= 18'h00000;
    end else if (clk_en) begin
      resonant_duty <= (mode_resonant && cfg_sel.resonant_fixed_duty_select)
                       ? thr_full(hi_upper_r) : filter_duty;
    end
  end

  // limit fault gate for the A/B pair
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ab_fault_kill <= 1'b0;
    end else if (clk_en) begin
      ab_fault_kill <= limit_fault & cfg_sel.ab_output_limit_affect;
    end
  end

  // limit fault gate for the C output
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      c_fault_kill <= 1'b0;
    end else if (clk_en) begin
      c_fault_kill <= limit_fault & cfg_sel.c_output_limit_affect;
    end
  end

endmodule : pams_auto_switch
`default_nettype wire

// ==== src/pams_map.svh ====
// Purpose: register offsets, field positions and reset values for the auto switch block
// Assumes: byte addresses as printed for instance 0
// Notes:   definitions only
`ifndef PAMS_MAP_SVH
`define PAMS_MAP_SVH
`define PAMS_ADDR_W          24
`define PAMS_OFF_HI_UPPER    24'h1d0068
`define PAMS_OFF_HI_LOWER    24'h1d006c
`define PAMS_OFF_LO_UPPER    24'h1d0070
`define PAMS_OFF_LO_LOWER    24'h1d0074
`define PAMS_OFF_CFG_MAX     24'h1d0078
`define PAMS_OFF_CFG_MID     24'h1d007c
`define PAMS_THR_MSB         17
`define PAMS_THR_LSB         4
`define PAMS_THR_RST         14'h0000
`define PAMS_B_SEL_MSB       31
`define PAMS_B_SEL_LSB       28
`define PAMS_A_SEL_MSB       27
`define PAMS_A_SEL_LSB       24
`define PAMS_C_LIM_BIT       23
`define PAMS_AB_LIM_BIT      20
`define PAMS_MATCH_BIT       19
`define PAMS_FIXDUTY_BIT     12
`define PAMS_MODE_MSB        6
`define PAMS_MODE_LSB        4
`define PAMS_ACCEL_BIT       1
`define PAMS_CFG_MAX_RST     32'h0000_0000
`define PAMS_CFG_MID_RST     32'h0000_0002
`define PAMS_SEL_MAX_CODE    4'h8
`endif

// ==== src/pams_pkg.sv ====
// Purpose: types for the auto switch configuration block
// Assumes: numbers given as literals here, map header not included
// Notes:   one applied configuration travels as a struct
package pams_pkg;
  typedef enum logic [2:0] {
    PAMS_MODE_NORMAL    = 3'h0,
    PAMS_MODE_RESONANT  = 3'h1,
    PAMS_MODE_MULTI     = 3'h2,
    PAMS_MODE_TRIANGLE  = 3'h3,
    PAMS_MODE_LEADING   = 3'h4
  } pams_mode_t;

  typedef enum logic [3:0] {
    PAMS_SEL_PASS       = 4'h0,
    PAMS_SEL_EDGE       = 4'h1,
    PAMS_SEL_LOCAL_C    = 4'h2,
    PAMS_SEL_CROSS      = 4'h3,
    PAMS_SEL_BELOW_A    = 4'h4,
    PAMS_SEL_BELOW_B    = 4'h5,
    PAMS_SEL_BELOW_C    = 4'h6,
    PAMS_SEL_BELOW2_C   = 4'h7,
    PAMS_SEL_BELOW3_C   = 4'h8
  } pams_sel_t;

  typedef enum logic {
    PAMS_USE_MID,
    PAMS_USE_MAX
  } pams_band_t;

  typedef struct packed {
    logic [3:0] b_output_selector;
    logic [3:0] a_output_selector;
    logic       c_output_limit_affect;
    logic       ab_output_limit_affect;
    logic       limit_or_pulse_match_enable;
    logic       resonant_fixed_duty_select;
    logic [2:0] mode;
    logic       loop_accel_input_enable;
  } pams_cfg_t;

  typedef struct packed {
    logic       limit_enable;
    logic       pulse_match;
    logic       ab_limit_gate;
    logic       c_limit_gate;
    logic       use_fixed_duty;
    logic       use_loop_accel;
  } pams_ctl_t;
endpackage : pams_pkg
